//--- hdl/twoc_consts.vh
// Constants for the timer waveform and compare-output control block
`ifndef TWOC_CONSTS_VH
`define TWOC_CONSTS_VH
// ==========================================================
// Register indices, one aligned word each
`define TWOC_IDX_CTRL_A 8'hB0
`define TWOC_IDX_CTRL_B 8'hB1
`define TWOC_IDX_CMP_A 8'hB2
`define TWOC_IDX_CMP_B 8'hB3
`define TWOC_IDX_COUNT 8'hB4
`define TWOC_IDX_STATUS 8'hB5
`define TWOC_IDX_MASK 8'hB6
`define TWOC_IDX_PINCTL 8'hB7
// Byte addresses are four times the index
`define TWOC_ADDR_CTRL_A {`TWOC_IDX_CTRL_A, 2'b00}
`define TWOC_ADDR_CTRL_B {`TWOC_IDX_CTRL_B, 2'b00}
`define TWOC_ADDR_CMP_A {`TWOC_IDX_CMP_A, 2'b00}
`define TWOC_ADDR_CMP_B {`TWOC_IDX_CMP_B, 2'b00}
`define TWOC_ADDR_COUNT {`TWOC_IDX_COUNT, 2'b00}
`define TWOC_ADDR_STATUS {`TWOC_IDX_STATUS, 2'b00}
`define TWOC_ADDR_MASK {`TWOC_IDX_MASK, 2'b00}
`define TWOC_ADDR_PINCTL {`TWOC_IDX_PINCTL, 2'b00}
// ==========================================================
// Field positions
`define TWOC_A_ACT_HI 7
`define TWOC_A_ACT_LO 6
`define TWOC_B_ACT_HI 5
`define TWOC_B_ACT_LO 4
`define TWOC_MODE_LOW_HI 1
`define TWOC_MODE_LOW_LO 0
`define TWOC_MODE_HIGH_BIT 3
`define TWOC_CTRL_A_WMASK 8'hF3
`define TWOC_CTRL_B_WMASK 8'h08
`define TWOC_ST_OVF 0
`define TWOC_ST_CMPA 1
`define TWOC_ST_CMPB 2
`define TWOC_ST_WIDTH 3
// ==========================================================
// Values
`define TWOC_RESET_BYTE 8'h00
`define TWOC_MAX 8'hFF
`define TWOC_BOTTOM 8'h00
`define TWOC_ONE 8'h01
`define TWOC_ACT_OFF 2'b00
`define TWOC_ACT_TOGGLE 2'b01
`define TWOC_ACT_CLEAR 2'b10
`define TWOC_ACT_SET 2'b11
`define TWOC_MODE_NORMAL 3'd0
`define TWOC_MODE_PC_FF 3'd1
`define TWOC_MODE_CTC 3'd2
`define TWOC_MODE_FAST_FF 3'd3
`define TWOC_MODE_RSV4 3'd4
`define TWOC_MODE_PC_A 3'd5
`define TWOC_MODE_RSV6 3'd6
`define TWOC_MODE_FAST_A 3'd7
`define TWOC_RESP_OKAY 2'b00
`define TWOC_RESP_SLVERR 2'b10
`endif

//--- hdl/twoc_top.v
// Timer waveform generation and compare-output control with AXI4-Lite
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "twoc_consts.vh"
module twoc_top #(
    parameter ADDR_WIDTH = 10
) (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire dir_a,
    input wire dir_b,
    input wire port_a,
    input wire port_b,
    output reg pin_a,
    output reg pin_a_oe_n,
    output reg pin_b,
    output reg pin_b_oe_n,
    output wire irq
);

// ==========================================================
// Registers
reg [7:0] ctrl_a_reg;
reg [7:0] ctrl_b_reg;
reg [7:0] cmp_a_buf_reg;
reg [7:0] cmp_b_buf_reg;
reg [7:0] cmp_a_reg;
reg [7:0] cmp_b_reg;
reg [7:0] count_reg;
reg count_down_reg;
reg [2:0] status_reg;
reg [2:0] mask_reg;
reg compare_out_a;
reg compare_out_b;
reg [ADDR_WIDTH-1:0] aw_addr_reg;
reg aw_held_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_held_reg;

wire [1:0] out_a_action = ctrl_a_reg[`TWOC_A_ACT_HI:`TWOC_A_ACT_LO];
wire [1:0] out_b_action = ctrl_a_reg[`TWOC_B_ACT_HI:`TWOC_B_ACT_LO];
wire out_a_action_high = out_a_action[1];
wire out_b_action_high = out_b_action[1];
wire wave_mode_high = ctrl_b_reg[`TWOC_MODE_HIGH_BIT];
wire [1:0] wave_mode_low =
    ctrl_a_reg[`TWOC_MODE_LOW_HI:`TWOC_MODE_LOW_LO];
wire [2:0] wave_mode_field = {wave_mode_high, wave_mode_low};

// ==========================================================
// Mode decode
function [2:0] twoc_class;
    // Returns {fast, phase_correct, non_pwm}
    input [2:0] m;
    begin
        case (m)
            `TWOC_MODE_NORMAL, `TWOC_MODE_CTC: twoc_class = 3'b001;
            `TWOC_MODE_PC_FF, `TWOC_MODE_PC_A: twoc_class = 3'b010;
            `TWOC_MODE_FAST_FF, `TWOC_MODE_FAST_A: twoc_class = 3'b100;
            default: twoc_class = 3'b000;
        endcase
    end
endfunction

wire [2:0] cls = twoc_class(wave_mode_field);
wire non_pwm = cls[0];
wire phase_pwm = cls[1];
wire fast_pwm = cls[2];
wire top_is_a = (wave_mode_field == `TWOC_MODE_CTC) ||
    (wave_mode_field == `TWOC_MODE_PC_A) ||
    (wave_mode_field == `TWOC_MODE_FAST_A);
wire [7:0] top_value = top_is_a ? cmp_a_reg : `TWOC_MAX;
wire at_top = (count_reg == top_value);
wire at_bottom = (count_reg == `TWOC_BOTTOM);
wire match_a = (count_reg == cmp_a_reg);
wire match_b = (count_reg == cmp_b_reg);

// ==========================================================
// Counter sequence
reg [7:0] count_next;
reg down_next;
always @* begin
    count_next = count_reg + `TWOC_ONE;
    down_next = count_down_reg;
    if (phase_pwm) begin
        if (!count_down_reg && at_top) begin
            down_next = 1'b1;
            count_next = count_reg - `TWOC_ONE;
        end else if (count_down_reg && at_bottom) begin
            down_next = 1'b0;
            count_next = count_reg + `TWOC_ONE;
        end else if (count_down_reg) begin
            count_next = count_reg - `TWOC_ONE;
        end
    end else if ((wave_mode_field == `TWOC_MODE_CTC) || fast_pwm) begin
        down_next = 1'b0;
        if (at_top) begin
            count_next = `TWOC_BOTTOM;
        end
    end else begin
        down_next = 1'b0;
    end
end

// Compare buffers load at the mode's update point
wire load_cmp = non_pwm || !(phase_pwm || fast_pwm) ||
    (phase_pwm && at_top) || (fast_pwm && at_bottom);

// Overflow event
wire ovf_evt = ((wave_mode_field == `TWOC_MODE_NORMAL) ||
    (wave_mode_field == `TWOC_MODE_CTC) ||
    (wave_mode_field == `TWOC_MODE_FAST_FF)) ? (count_reg == `TWOC_MAX) :
    phase_pwm ? (at_bottom && count_down_reg) :
    (wave_mode_field == `TWOC_MODE_FAST_A) ? at_top : 1'b0;

// ==========================================================
// Waveform output per channel
function [1:0] twoc_wave;
    // Returns {change, new_value}
    input [2:0] c;
    input is_b;
    input [1:0] act;
    input mode_hi;
    input cur;
    input match;
    input cmp_is_top;
    input top;
    input bottom;
    input down;
    reg pol;
    begin
        twoc_wave = {1'b0, cur};
        pol = act[0];
        if (c[0]) begin
            if (match) begin
                case (act)
                    `TWOC_ACT_TOGGLE: twoc_wave = {1'b1, ~cur};
                    `TWOC_ACT_CLEAR: twoc_wave = 2'b10;
                    `TWOC_ACT_SET: twoc_wave = 2'b11;
                    default: twoc_wave = {1'b0, cur};
                endcase
            end
        end else if (c[2]) begin
            if (act == `TWOC_ACT_TOGGLE) begin
                if (!is_b && mode_hi && match) begin
                    twoc_wave = {1'b1, ~cur};
                end
            end else if (act[1]) begin
                if (cmp_is_top) begin
                    if (bottom) twoc_wave = {1'b1, ~pol};
                end else if (match) begin
                    twoc_wave = {1'b1, pol};
                end else if (bottom) begin
                    twoc_wave = {1'b1, ~pol};
                end
            end
        end else if (c[1]) begin
            if (act == `TWOC_ACT_TOGGLE) begin
                if (!is_b && mode_hi && match) begin
                    twoc_wave = {1'b1, ~cur};
                end
            end else if (act[1]) begin
                if (cmp_is_top) begin
                    if (top) twoc_wave = {1'b1, ~pol};
                end else if (match) begin
                    twoc_wave = {1'b1, down ? ~pol : pol};
                end
            end
        end
    end
endfunction

wire [1:0] wave_a = twoc_wave(cls, 1'b0, out_a_action, wave_mode_high,
    compare_out_a, match_a, out_a_action_high && (cmp_a_reg == top_value),
    at_top, at_bottom, count_down_reg);
wire [1:0] wave_b = twoc_wave(cls, 1'b1, out_b_action, wave_mode_high,
    compare_out_b, match_b, out_b_action_high && (cmp_b_reg == top_value),
    at_top, at_bottom, count_down_reg);

// ==========================================================
// Pin ownership per channel
function twoc_owns;
    // Channel A action 01 in a PWM class without the high
    // mode bit leaves the pin with the port
    input [2:0] c;
    input is_b;
    input [1:0] act;
    input mode_hi;
    begin
        case (act)
            `TWOC_ACT_OFF: twoc_owns = 1'b0;
            `TWOC_ACT_TOGGLE: begin
                if ((c[1] || c[2]) && !is_b && !mode_hi) begin
                    twoc_owns = 1'b0;
                end else begin
                    twoc_owns = 1'b1;
                end
            end
            default: twoc_owns = 1'b1;
        endcase
    end
endfunction

wire own_a = twoc_owns(cls, 1'b0, out_a_action, wave_mode_high);
wire own_b = twoc_owns(cls, 1'b1, out_b_action, wave_mode_high);

// ==========================================================
// AXI4-Lite slave
wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
wire do_read = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire [7:0] wbyte = w_data_reg[7:0];
wire wlane = w_strb_reg[0];
wire [2:0] wclr = (do_write && wlane &&
    aw_addr_reg == `TWOC_ADDR_STATUS) ? wbyte[2:0] : 3'b000;
wire [2:0] evts = {match_b, match_a, ovf_evt};

function twoc_known;
    input [ADDR_WIDTH-1:0] a;
    begin
        case (a)
            `TWOC_ADDR_CTRL_A, `TWOC_ADDR_CTRL_B, `TWOC_ADDR_CMP_A,
            `TWOC_ADDR_CMP_B, `TWOC_ADDR_COUNT, `TWOC_ADDR_STATUS,
            `TWOC_ADDR_MASK, `TWOC_ADDR_PINCTL: twoc_known = 1'b1;
            default: twoc_known = 1'b0;
        endcase
    end
endfunction

reg [7:0] rbyte;
always @* begin
    case (s_axi_araddr)
        `TWOC_ADDR_CTRL_A: rbyte = ctrl_a_reg & `TWOC_CTRL_A_WMASK;
        `TWOC_ADDR_CTRL_B: rbyte = ctrl_b_reg & `TWOC_CTRL_B_WMASK;
        `TWOC_ADDR_CMP_A: rbyte = cmp_a_buf_reg;
        `TWOC_ADDR_CMP_B: rbyte = cmp_b_buf_reg;
        `TWOC_ADDR_COUNT: rbyte = count_reg;
        `TWOC_ADDR_STATUS: rbyte = {5'b00000, status_reg};
        `TWOC_ADDR_MASK: rbyte = {5'b00000, mask_reg};
        `TWOC_ADDR_PINCTL: rbyte = {6'b000000, compare_out_b, compare_out_a};
        default: rbyte = `TWOC_RESET_BYTE;
    endcase
end

assign irq = |(status_reg & mask_reg);

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        ctrl_a_reg <= `TWOC_RESET_BYTE;
        ctrl_b_reg <= `TWOC_RESET_BYTE;
        cmp_a_buf_reg <= `TWOC_RESET_BYTE;
        cmp_b_buf_reg <= `TWOC_RESET_BYTE;
        cmp_a_reg <= `TWOC_RESET_BYTE;
        cmp_b_reg <= `TWOC_RESET_BYTE;
        count_reg <= `TWOC_RESET_BYTE;
        count_down_reg <= 1'b0;
        status_reg <= 3'b000;
        mask_reg <= 3'b000;
        compare_out_a <= 1'b0;
        compare_out_b <= 1'b0;
        aw_addr_reg <= {ADDR_WIDTH{1'b0}};
        aw_held_reg <= 1'b0;
        w_data_reg <= 32'h0000_0000;
        w_strb_reg <= 4'h0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TWOC_RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `TWOC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        pin_a_oe_n <= 1'b1;
        pin_b_oe_n <= 1'b1;
    end else if (clk_en) begin
        count_reg <= count_next;
        count_down_reg <= down_next;
        if (wave_a[1]) compare_out_a <= wave_a[0];
        if (wave_b[1]) compare_out_b <= wave_b[0];
        if (load_cmp) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
        end
        // Set beats a simultaneous write-one clear
        status_reg <= (status_reg & ~wclr) | evts;
        // Pin mux: compare output replaces port data when action set, except channel A action 01 in a PWM class without the high mode bit
        pin_a <= own_a ? compare_out_a : port_a;
        pin_b <= own_b ? compare_out_b : port_b;
        pin_a_oe_n <= ~dir_a;
        pin_b_oe_n <= ~dir_b;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
        end
        if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= twoc_known(aw_addr_reg) ?
                `TWOC_RESP_OKAY : `TWOC_RESP_SLVERR;
            if (wlane) begin
                case (aw_addr_reg)
                    `TWOC_ADDR_CTRL_A:
                        ctrl_a_reg <= wbyte & `TWOC_CTRL_A_WMASK;
                    `TWOC_ADDR_CTRL_B:
                        ctrl_b_reg <= wbyte & `TWOC_CTRL_B_WMASK;
                    `TWOC_ADDR_CMP_A: cmp_a_buf_reg <= wbyte;
                    `TWOC_ADDR_CMP_B: cmp_b_buf_reg <= wbyte;
                    `TWOC_ADDR_COUNT: count_reg <= wbyte;
                    `TWOC_ADDR_MASK: mask_reg <= wbyte[2:0];
                    default: ;
                endcase
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rbyte};
            s_axi_rresp <= twoc_known(s_axi_araddr) ?
                `TWOC_RESP_OKAY : `TWOC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // twoc_top

//--- bench/twoc_props.sv
// Concurrent checks on bus handshakes, pin enables and interrupt
module twoc_props (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire dir_a,
    input wire dir_b,
    input wire pin_a_oe_n,
    input wire pin_b_oe_n,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Handshake steps
    default clocking cb @(posedge clock);
    endclocking
    // Frozen timer freezes the slave too, so checks pause
    default disable iff (!rstn || !clk_en);
    sequence s_aw_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========================================================
    // Properties
    a_write_answer: assert property (s_aw_w |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_ar |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_oe_dir_a: assert property ($past(rstn) && $past(clk_en)
        |-> pin_a_oe_n == !$past(dir_a))
        else $error("pin a enable wrong");
    a_oe_dir_b: assert property ($past(rstn) && $past(clk_en)
        |-> pin_b_oe_n == !$past(dir_b))
        else $error("pin b enable wrong");
    a_irq_fall_write: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt fell without a write");
endmodule // twoc_props

bind twoc_top twoc_props u_props (
    .clock(clock), .rstn(rstn), .clk_en(clk_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dir_a(dir_a), .dir_b(dir_b), .pin_a_oe_n(pin_a_oe_n),
    .pin_b_oe_n(pin_b_oe_n), .irq(irq)
);

//--- bench/twoc_pad.sv
// Pad model of one output pin and its port logic
module twoc_pad (
    input wire clock,
    input wire pin,
    input wire pin_oe_n,
    output logic pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg = 1'b0;
    always @(posedge clock) begin
        if (!pin_oe_n)
            last_reg <= pin;
    end
    // No pull on the pad, so an undriven pad must not look driven
    assign pad = pin_oe_n ? ~last_reg : pin;
endmodule // twoc_pad

//--- bench/tb.sv
// Self-checking bench for the timer waveform control block
`include "twoc_consts.vh"
`define TWOC_CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("BAD %0t got %0h exp %0h", $time, g, e); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic dir_a = 1'b0, dir_b = 1'b0, port_a = 1'b0, port_b = 1'b0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_2f82;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire pin_a, pin_b, oe_a, oe_b, pad_a, pad_b;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    logic [33:0] qr[$];
    logic [1:0] qb[$];
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    twoc_top u_dut (
        .clock(clock), .rstn(rstn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dir_a(dir_a), .dir_b(dir_b), .port_a(port_a), .port_b(port_b),
        .pin_a(pin_a), .pin_a_oe_n(oe_a), .pin_b(pin_b), .pin_b_oe_n(oe_b),
        .irq(irq)
    );
    twoc_pad u_pad_a (.clock(clock), .pin(pin_a), .pin_oe_n(oe_a),
        .pad(pad_a));
    twoc_pad u_pad_b (.clock(clock), .pin(pin_b), .pin_oe_n(oe_b),
        .pad(pad_b));

    always #2.5 clock = ~clock;
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic pk(input logic s);
        return s ? pad_b : pad_a;
    endfunction
    task final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end
    always @(posedge clock) begin
        if (rvalid && rready)
            `TWOC_CHK({rresp, rdata}, qr.pop_front())
        if (bvalid && bready)
            `TWOC_CHK(bresp, qb.pop_front())
    end
    // Entered and left just after a rising edge
    task automatic bus(input logic w, input logic [9:0] a,
        input logic [7:0] d, input logic [1:0] r);
        logic ta, tw, tr;
        if (w) begin
            qb.push_back(r);
            awaddr <= a;
            wdata <= {24'h00_0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
        end else begin
            qr.push_back({r, 24'h00_0000, d});
            araddr <= a;
            arvalid <= 1'b1;
        end
        do begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end while (awvalid || wvalid || arvalid);
        repeat (rnd() % 3) @(posedge clock);
        bready <= w;
        rready <= !w;
        do @(negedge clock); while (!(w ? bvalid : rvalid));
        @(posedge clock);
        bready <= 1'b0;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, `TWOC_RESP_OKAY);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] d);
        bus(1'b0, a, d, `TWOC_RESP_OKAY);
    endtask
    task automatic irq_is(input logic e);
        @(negedge clock);
        `TWOC_CHK(irq, e)
        @(posedge clock);
    endtask
    task automatic duty(input logic s, input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clock);
            h += pk(s);
        end
        @(posedge clock);
    endtask
    // Samples mid-period, away from the toggle edge
    task automatic tog(input logic s);
        logic p;
        p = pk(s);
        for (int i = 0; i < 300 && p === pk(s); i++)
            @(negedge clock);
        repeat (128) @(negedge clock);
        p = pk(s);
        repeat (256) @(negedge clock);
        `TWOC_CHK(pk(s), ~p)
        @(posedge clock);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        int c, n, h;
        int hs[4];
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(`TWOC_ADDR_CTRL_A, 8'h00);
        wr(`TWOC_ADDR_CTRL_A, 8'hFF);
        rd(`TWOC_ADDR_CTRL_A, 8'hF3);
        wr(`TWOC_ADDR_CTRL_B, 8'hFF);
        rd(`TWOC_ADDR_CTRL_B, 8'h08);
        bus(1'b1, 10'h340, 8'h55, `TWOC_RESP_SLVERR);
        bus(1'b0, 10'h340, 8'h00, `TWOC_RESP_SLVERR);
        c = rnd();
        wr(`TWOC_ADDR_CMP_B, c[7:0]);
        rd(`TWOC_ADDR_CMP_B, c[7:0]);
        $display("test registers done");
        wr(`TWOC_ADDR_CMP_A, 8'h80);
        wr(`TWOC_ADDR_CMP_B, 8'h40);
        for (int m = 0; m < 8; m++) begin
            wr(`TWOC_ADDR_CTRL_A, {6'h00, m[1:0]});
            wr(`TWOC_ADDR_CTRL_B, {4'h0, m[2], 3'h0});
            wr(`TWOC_ADDR_COUNT, 8'h00);
            wr(`TWOC_ADDR_STATUS, 8'h07);
            repeat (600) @(posedge clock);
            rd(`TWOC_ADDR_STATUS, 8'h06 | ((8'hAB >> m) & 8'h01));
        end
        $display("test modes done");
        wr(`TWOC_ADDR_CTRL_A, 8'h00);
        wr(`TWOC_ADDR_MASK, 8'h01);
        irq_is(1'b1);
        wr(`TWOC_ADDR_MASK, 8'h00);
        irq_is(1'b0);
        wr(`TWOC_ADDR_MASK, 8'h01);
        wr(`TWOC_ADDR_STATUS, 8'h01);
        irq_is(1'b0);
        $display("test interrupt done");
        wr(`TWOC_ADDR_CTRL_B, 8'h00);
        for (int i = 0; i < 8; i++) begin
            c = rnd();
            dir_a <= c[0];
            port_a <= c[1];
            dir_b <= c[2];
            port_b <= c[3];
            repeat (3) @(negedge clock);
            `TWOC_CHK({oe_a, oe_b}, ~{c[0], c[2]})
            `TWOC_CHK({pin_a, pin_b}, {c[1], c[3]})
            @(posedge clock);
        end
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        wr(`TWOC_ADDR_CMP_A, 8'h10);
        wr(`TWOC_ADDR_CMP_B, 8'h90);
        wr(`TWOC_ADDR_CTRL_A, 8'h50);
        tog(1'b0);
        tog(1'b1);
        // Frozen timer must not toggle across a match
        clk_en <= 1'b0;
        repeat (2) @(negedge clock);
        n = pad_a;
        repeat (300) @(negedge clock);
        `TWOC_CHK(pad_a, n[0])
        @(posedge clock);
        clk_en <= 1'b1;
        for (int k = 2; k < 4; k++) begin
            wr(`TWOC_ADDR_CTRL_A, {k[1:0], k[1:0], 4'h0});
            repeat (300) @(negedge clock);
            `TWOC_CHK({pad_a, pad_b}, {2{k[0]}})
            @(posedge clock);
        end
        $display("test non-pwm done");
        c = 32 + rnd() % 192;
        wr(`TWOC_ADDR_CMP_A, c[7:0]);
        wr(`TWOC_ADDR_CMP_B, c[7:0]);
        for (int m = 1; m < 4; m += 2) begin
            n = (m == 3) ? 256 : 510;
            for (int k = 2; k < 4; k++) begin
                wr(`TWOC_ADDR_CTRL_A, {k[1:0], k[1:0], 2'h0, m[1:0]});
                repeat (600) @(posedge clock);
                duty(1'b0, n, hs[k]);
                duty(1'b1, n, h);
                `TWOC_CHK(h, hs[k])
            end
            `TWOC_CHK(hs[2] + hs[3], n)
            h = (m == 3) ? c : 2 * c;
            `TWOC_CHK(hs[2] >= h - 2 && hs[2] <= h + 2, 1'b1)
        end
        wr(`TWOC_ADDR_CTRL_A, 8'h43);
        port_a <= ~port_a;
        repeat (3) @(negedge clock);
        `TWOC_CHK(pin_a, port_a)
        @(posedge clock);
        wr(`TWOC_ADDR_CTRL_A, 8'h23);
        wr(`TWOC_ADDR_CTRL_B, 8'h08);
        repeat (600) @(posedge clock);
        duty(1'b1, 256, h);
        `TWOC_CHK(h, 256)
        $display("test pwm done");
        final_report();
    end
endmodule // tb
